// ---- core/bsl_pkg.sv ----
// Purpose: constants and types shared by the strap latch block
// Assumes: one clock domain, mclk_i at 40 MHz
// Notes:   fuse inputs are static and valid whenever reset is active
package bsl_pkg;

	// -----------------------------------------------------------------
	// clock and timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned RST_MIN_US     = 50;
	localparam int unsigned RST_MIN_CYC    = (RST_MIN_US * (CLK_HZ / 1_000_000));
	localparam int unsigned SYNC_STAGES    = 2;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [3:0]  ADDR_STRAP     = 4'h0;
	localparam logic [3:0]  ADDR_SELECT    = 4'h4;
	localparam logic [3:0]  ADDR_CTRL      = 4'h8;
	localparam logic [31:0] RDATA_NONE     = 32'h0000_0000;

	// strap field positions
	localparam int unsigned STRAP_W        = 4;
	localparam int unsigned BIT_BOOT_MODE  = 0;
	localparam int unsigned BIT_IO_VOLT    = 1;
	localparam int unsigned BIT_PRINT      = 2;
	localparam int unsigned BIT_DEBUG_SRC  = 3;

	// ctrl word: software mute of serial printing
	localparam int unsigned BIT_MUTE       = 0;

	// pull enables per strap pin: pull-up on boot mode, pull-down on two
	localparam logic [3:0]  PULL_UP_MASK   = 4'h1;
	localparam logic [3:0]  PULL_DN_MASK   = 4'h6;
	localparam logic [3:0]  STRAP_RST      = 4'h0;

	// -----------------------------------------------------------------
	// encodings
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		BSL_JTAG_NONE = 2'h0,
		BSL_JTAG_PINS = 2'h1,
		BSL_JTAG_USB  = 2'h2
	} bsl_jtag_t;

	typedef enum logic [1:0] {
		BSL_BOOT_DOWNLOAD = 2'h0,
		BSL_BOOT_FLASH    = 2'h1,
		BSL_BOOT_INVALID  = 2'h2
	} bsl_boot_t;

	typedef enum logic [1:0] {
		BSL_PG_ALWAYS  = 2'h0,
		BSL_PG_LOW     = 2'h1,
		BSL_PG_HIGH    = 2'h2,
		BSL_PG_NEVER   = 2'h3
	} bsl_pgate_t;

	// flash supply level: 0 = 3.3 V, 1 = 1.8 V
	localparam logic        SUPPLY_3V3     = 1'b0;
	localparam logic        SUPPLY_1V8     = 1'b1;

	// print route: 0 = serial port, 1 = usb serial/debug controller
	localparam logic        ROUTE_SERIAL   = 1'b0;
	localparam logic        ROUTE_USB      = 1'b1;

	typedef enum logic [2:0] {
		BSL_ST_RESET   = 3'b001,
		BSL_ST_SAMPLE  = 3'b010,
		BSL_ST_RUN     = 3'b100
	} bsl_state_t;

endpackage

// ---- core/bsl_sel_if.sv ----
// Purpose: carries held strap bits and fuses to the selection logic
// Assumes: all members on mclk_i domain
// Notes:   selector drives the decoded choices back
`timescale 1ns/10ps
interface bsl_sel_if;
	logic [3:0]           strap;
	logic                 fuse_debug_strap_select;
	logic                 fuse_usb_debug_off;
	logic                 fuse_pin_debug_off;
	logic                 fuse_flash_supply_force;
	logic                 fuse_flash_supply_high;
	logic                 fuse_print_port_select;
	logic                 fuse_usb_serial_off;
	logic                 fuse_usb_device_off;
	logic [1:0]           fuse_print_gate_mode;
	bsl_pkg::bsl_jtag_t   jtag_src;
	bsl_pkg::bsl_boot_t   boot_mode;
	logic                 supply_1v8;
	logic                 print_usb;
	logic                 print_enable;
	logic                 print_secondary;

	modport latch (
		output strap, fuse_debug_strap_select, fuse_usb_debug_off, fuse_pin_debug_off,
		output fuse_flash_supply_force, fuse_flash_supply_high, fuse_print_port_select,
		output fuse_usb_serial_off, fuse_usb_device_off, fuse_print_gate_mode,
		input  jtag_src, boot_mode, supply_1v8, print_usb, print_enable, print_secondary
	);
	modport sel (
		input  strap, fuse_debug_strap_select, fuse_usb_debug_off, fuse_pin_debug_off,
		input  fuse_flash_supply_force, fuse_flash_supply_high, fuse_print_port_select,
		input  fuse_usb_serial_off, fuse_usb_device_off, fuse_print_gate_mode,
		output jtag_src, boot_mode, supply_1v8, print_usb, print_enable, print_secondary
	);
endinterface

// ---- core/bsl_select.sv ----
// Purpose: decodes boot, supply, debug and print choices
// Assumes: inputs static after reset
// Notes:   purely combinational
`timescale 1ns/10ps
module bsl_select (
	bsl_sel_if.sel s
);
	logic boot_b;
	logic prt_b;
	logic dbg_b;

	always_comb begin
		boot_b = s.strap[bsl_pkg::BIT_BOOT_MODE];
		prt_b  = s.strap[bsl_pkg::BIT_PRINT];
		dbg_b  = s.strap[bsl_pkg::BIT_DEBUG_SRC];
		// debug source
		unique case ({s.fuse_usb_debug_off, s.fuse_pin_debug_off})
			2'h0: begin
				if (s.fuse_debug_strap_select) begin
					s.jtag_src = dbg_b ? bsl_pkg::BSL_JTAG_USB : bsl_pkg::BSL_JTAG_PINS;
				end else begin
					s.jtag_src = bsl_pkg::BSL_JTAG_USB;
				end
			end
			2'h1: s.jtag_src = bsl_pkg::BSL_JTAG_USB;
			2'h2: s.jtag_src = bsl_pkg::BSL_JTAG_PINS;
			2'h3: s.jtag_src = bsl_pkg::BSL_JTAG_NONE;
		endcase
		// boot mode
		if (boot_b) begin
			s.boot_mode = bsl_pkg::BSL_BOOT_FLASH;
		end else if (prt_b) begin
			s.boot_mode = bsl_pkg::BSL_BOOT_INVALID;
		end else begin
			s.boot_mode = bsl_pkg::BSL_BOOT_DOWNLOAD;
		end
		// flash supply; fuse high means 3.3 V
		if (s.fuse_flash_supply_force) begin
			s.supply_1v8 = s.fuse_flash_supply_high ? bsl_pkg::SUPPLY_3V3 : bsl_pkg::SUPPLY_1V8;
		end else begin
			s.supply_1v8 = s.strap[bsl_pkg::BIT_IO_VOLT];
		end
		// print routing and gating
		s.print_usb       = !s.fuse_usb_serial_off && !s.fuse_usb_device_off;
		s.print_secondary = s.fuse_print_port_select;
		unique case (bsl_pkg::bsl_pgate_t'(s.fuse_print_gate_mode))
			bsl_pkg::BSL_PG_ALWAYS: s.print_enable = 1'b1;
			bsl_pkg::BSL_PG_LOW:    s.print_enable = !prt_b;
			bsl_pkg::BSL_PG_HIGH:   s.print_enable = prt_b;
			bsl_pkg::BSL_PG_NEVER:  s.print_enable = 1'b0;
		endcase
	end
endmodule

// ---- core/bsl_top.sv ----
// Purpose: boot strap latch: samples four strap pins during reset
// Assumes: srst_i high covers every system reset cause; fuses static
// Notes:   pins pass a two-stage synchroniser before sampling
`timescale 1ns/10ps

// Contract
// - capture strap levels during reset, hold them
// - software reads held strap bits via register
// - release pins after reset, bits unchanged
// - weak pulls on three straps during reset
// - fuses choose debug source
// - strap bit picks pins or usb debug
// - boot mode from boot and print straps
// - flash supply from strap or fuses
// - fuse picks primary or secondary serial
// - usb print unless usb fuses disable
// - gate mode controls serial printing
module bsl_top (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  strap_pin_i,
	input  wire logic        fuse_debug_strap_select_i,
	input  wire logic        fuse_usb_debug_off_i,
	input  wire logic        fuse_pin_debug_off_i,
	input  wire logic        fuse_flash_supply_force_i,
	input  wire logic        fuse_flash_supply_high_i,
	input  wire logic        fuse_print_port_select_i,
	input  wire logic        fuse_usb_serial_off_i,
	input  wire logic        fuse_usb_device_off_i,
	input  wire logic [1:0]  fuse_print_gate_mode_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic      [3:0]  pull_up_en_o,
	output logic      [3:0]  pull_dn_en_o,
	output logic             strap_valid_o,
	output logic      [1:0]  jtag_src_o,
	output logic      [1:0]  boot_mode_o,
	output logic             flash_supply_1v8_o,
	output logic             print_usb_o,
	output logic             print_enable_o,
	output logic             print_secondary_o
);
	// -----------------------------------------------------------------
	// synchroniser
	// -----------------------------------------------------------------
	logic [3:0] sync1_q, sync1_d;
	logic [3:0] sync2_q, sync2_d;

	always_comb begin
		sync1_d = strap_pin_i;
		sync2_d = sync1_q;
	end

	always_ff @(posedge mclk_i) begin
		sync1_q <= sync1_d;
		sync2_q <= sync2_d;
	end

	// -----------------------------------------------------------------
	// sample sequencer
	// -----------------------------------------------------------------
	// sampling tracks the pins for the whole reset and reloads once more in SAMPLE,
	// so the synchronised level seen in the SAMPLE state is what is held
	bsl_pkg::bsl_state_t st_q, st_d;
	logic [3:0]          strap_q, strap_d;
	logic                valid_q, valid_d;

	always_comb begin
		st_d    = st_q;
		strap_d = strap_q;
		valid_d = valid_q;
		unique case (st_q)
			bsl_pkg::BSL_ST_RESET: begin
				st_d = bsl_pkg::BSL_ST_SAMPLE;
			end
			bsl_pkg::BSL_ST_SAMPLE: begin
				strap_d = sync2_q;
				valid_d = 1'b1;
				st_d    = bsl_pkg::BSL_ST_RUN;
			end
			bsl_pkg::BSL_ST_RUN: begin
				strap_d = strap_q;
			end
			default: begin
				st_d = bsl_pkg::BSL_ST_RESET;
			end
		endcase
		// track the pins for the whole reset; the held level is reloaded in SAMPLE
		if (srst_i) begin
			strap_d = sync2_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_q    <= bsl_pkg::BSL_ST_RESET;
			valid_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			valid_q <= valid_d;
		end
		strap_q <= strap_d;
	end

	// -----------------------------------------------------------------
	// pull control
	// -----------------------------------------------------------------
	// pulls stay on until the strap is frozen and drop on that same edge,
	// so valid and released pulls are never seen apart; debug strap gets none
	logic [3:0] pu_q, pu_d;
	logic [3:0] pd_q, pd_d;

	always_comb begin
		if (st_d == bsl_pkg::BSL_ST_RUN) begin
			pu_d = 4'h0;
			pd_d = 4'h0;
		end else begin
			pu_d = bsl_pkg::PULL_UP_MASK;
			pd_d = bsl_pkg::PULL_DN_MASK;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pu_q <= bsl_pkg::PULL_UP_MASK;
			pd_q <= bsl_pkg::PULL_DN_MASK;
		end else begin
			pu_q <= pu_d;
			pd_q <= pd_d;
		end
	end

	// -----------------------------------------------------------------
	// selection
	// -----------------------------------------------------------------
	bsl_sel_if sif ();

	always_comb begin
		sif.strap                   = strap_q;
		sif.fuse_debug_strap_select = fuse_debug_strap_select_i;
		sif.fuse_usb_debug_off      = fuse_usb_debug_off_i;
		sif.fuse_pin_debug_off      = fuse_pin_debug_off_i;
		sif.fuse_flash_supply_force = fuse_flash_supply_force_i;
		sif.fuse_flash_supply_high  = fuse_flash_supply_high_i;
		sif.fuse_print_port_select  = fuse_print_port_select_i;
		sif.fuse_usb_serial_off     = fuse_usb_serial_off_i;
		sif.fuse_usb_device_off     = fuse_usb_device_off_i;
		sif.fuse_print_gate_mode    = fuse_print_gate_mode_i;
	end

	bsl_select u_sel (
		.s (sif.sel)
	);

	// outputs registered to keep every top output on a flip-flop
	logic [1:0] jtag_q, jtag_d;
	logic [1:0] boot_q, boot_d;
	logic       v18_q, v18_d;
	logic       pusb_q, pusb_d;
	logic       pen_q, pen_d;
	logic       psec_q, psec_d;
	logic       pcfg_q, pcfg_d;

	always_comb begin
		jtag_d = sif.jtag_src;
		boot_d = sif.boot_mode;
		v18_d  = sif.supply_1v8;
		pusb_d = sif.print_usb;
		// mute folded in here so the output still comes from one flop
		pen_d  = sif.print_enable && !sif.print_usb && !pcfg_d;
		psec_d = sif.print_secondary;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			jtag_q <= 2'h0;
			boot_q <= 2'h0;
			v18_q  <= 1'b0;
			pusb_q <= 1'b0;
			pen_q  <= 1'b0;
			psec_q <= 1'b0;
		end else begin
			jtag_q <= jtag_d;
			boot_q <= boot_d;
			v18_q  <= v18_d;
			pusb_q <= pusb_d;
			pen_q  <= pen_d;
			psec_q <= psec_d;
		end
	end

	// -----------------------------------------------------------------
	// register port
	// -----------------------------------------------------------------
	// ctrl bit 0: software may mute serial printing after boot
	logic [31:0] rdata_q, rdata_d;

	always_comb begin
		pcfg_d = pcfg_q;
		if (wr_i && addr_i == bsl_pkg::ADDR_CTRL) begin
			pcfg_d = wdata_i[bsl_pkg::BIT_MUTE];
		end
		rdata_d = bsl_pkg::RDATA_NONE;
		if (rd_i) begin
			unique case (addr_i)
				bsl_pkg::ADDR_STRAP:  rdata_d = {27'h0, valid_q, strap_q};
				bsl_pkg::ADDR_SELECT: rdata_d = {24'h0, psec_q, pen_q, pusb_q, v18_q, boot_q, jtag_q};
				bsl_pkg::ADDR_CTRL:   rdata_d = {31'h0, pcfg_q};
				default:              rdata_d = bsl_pkg::RDATA_NONE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_q <= bsl_pkg::RDATA_NONE;
			pcfg_q  <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			pcfg_q  <= pcfg_d;
		end
	end

	assign rdata_o            = rdata_q;
	assign pull_up_en_o       = pu_q;
	assign pull_dn_en_o       = pd_q;
	assign strap_valid_o      = valid_q;
	assign jtag_src_o         = jtag_q;
	assign boot_mode_o        = boot_q;
	assign flash_supply_1v8_o = v18_q;
	assign print_usb_o        = pusb_q;
	assign print_enable_o     = pen_q;
	assign print_secondary_o  = psec_q;
endmodule

// ---- testbench/bsl_strap_model.sv ----
// Purpose: pull resistors or host outputs on the four strap pins
// Assumes: levels held until the latch reports valid
// Notes:   released pins carry changing traffic
`timescale 1ns/10ps
module bsl_strap_model (
	input  wire logic       mclk_i,
	input  wire logic       valid_i,
	input  wire logic [3:0] level_i,
	input  wire logic [3:0] drive_i,
	input  wire logic [3:0] pull_up_en_i,
	input  wire logic [3:0] pull_dn_en_i,
	output logic      [3:0] pin_o = 4'h0
);
	always @(posedge mclk_i) begin
		if (!valid_i) begin
			for (int k = 0; k < 4; k++) begin
				// a floating pin is never trusted to keep its last level
				pin_o[k] <= drive_i[k] ? level_i[k] : pull_up_en_i[k] ? 1'b1 :
					pull_dn_en_i[k] ? 1'b0 : ~pin_o[k];
			end
		end else begin
			pin_o <= pin_o + 4'h5;
		end
	end
endmodule

// ---- testbench/bsl_top_checker.sv ----
// Purpose: port assertions for the strap latch
// Assumes: one clock domain, reset active high
// Notes:   held strap bits are seen only through reads of the strap word
`timescale 1ns/10ps
module bsl_top_checker (
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic        fuse_debug_strap_select_i,
	input wire logic        fuse_usb_debug_off_i,
	input wire logic        fuse_pin_debug_off_i,
	input wire logic        fuse_flash_supply_force_i,
	input wire logic        fuse_flash_supply_high_i,
	input wire logic [3:0]  addr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [3:0]  pull_up_en_o,
	input wire logic [3:0]  pull_dn_en_o,
	input wire logic        strap_valid_o,
	input wire logic [1:0]  jtag_src_o,
	input wire logic [1:0]  boot_mode_o,
	input wire logic        flash_supply_1v8_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	logic strap_rd;
	// decoded outputs are judged against the strap word of the same read
	assign strap_rd = rd_i && addr_i == bsl_pkg::ADDR_STRAP && strap_valid_o;
	valid_rise_a: assert property (
		$fell(srst_i) |-> !strap_valid_o ##1 !strap_valid_o ##[1:3] strap_valid_o)
		else $error("strap valid out of time");
	valid_hold_a: assert property (
		strap_valid_o |=> strap_valid_o) else $error("strap valid dropped");
	pulls_on_a: assert property (
		!strap_valid_o |-> pull_up_en_o == bsl_pkg::PULL_UP_MASK
			&& pull_dn_en_o == bsl_pkg::PULL_DN_MASK) else $error("pulls off early");
	pulls_off_a: assert property (
		strap_valid_o |-> pull_up_en_o == 4'h0 && pull_dn_en_o == 4'h0)
		else $error("pulls left on");
	rdata_idle_a: assert property (
		!rd_i |=> rdata_o == 32'h0) else $error("read data without read");
	boot_map_a: assert property (
		strap_rd |=> rdata_o[4] && boot_mode_o == (rdata_o[0] ? 2'h1 : rdata_o[2] ? 2'h2 : 2'h0))
		else $error("boot mode mismatch");
	supply_map_a: assert property (
		strap_rd |=> flash_supply_1v8_o == (fuse_flash_supply_force_i ?
			!fuse_flash_supply_high_i : rdata_o[1])) else $error("supply mismatch");
	jtag_strap_a: assert property (
		strap_rd && fuse_debug_strap_select_i && !fuse_usb_debug_off_i && !fuse_pin_debug_off_i
		|=> jtag_src_o == (rdata_o[3] ? 2'h2 : 2'h1)) else $error("debug source mismatch");
	jtag_none_a: assert property (
		strap_valid_o && fuse_usb_debug_off_i && fuse_pin_debug_off_i |-> jtag_src_o == 2'h0)
		else $error("debug source not none");
endmodule
bind bsl_top bsl_top_checker chk (.mclk_i(mclk_i), .srst_i(srst_i),
	.fuse_debug_strap_select_i(fuse_debug_strap_select_i),
	.fuse_usb_debug_off_i(fuse_usb_debug_off_i), .fuse_pin_debug_off_i(fuse_pin_debug_off_i),
	.fuse_flash_supply_force_i(fuse_flash_supply_force_i),
	.fuse_flash_supply_high_i(fuse_flash_supply_high_i), .addr_i(addr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .pull_up_en_o(pull_up_en_o), .pull_dn_en_o(pull_dn_en_o),
	.strap_valid_o(strap_valid_o), .jtag_src_o(jtag_src_o), .boot_mode_o(boot_mode_o),
	.flash_supply_1v8_o(flash_supply_1v8_o));

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the strap latch
// Assumes: fuses change only while reset is held
// Notes:   random straps and drive masks per reset; gate mode and debug-off fuses stepped by reset count, other fuses random
`timescale 1ns/10ps
module tb_top;
	logic        mclk_i  = 1'b0;
	logic        srst_i  = 1'b1;
	logic [9:0]  fz      = 10'h000;
	logic [3:0]  lvl     = 4'hF;
	logic [3:0]  drv     = 4'hF;
	logic [3:0]  addr_i  = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [3:0]  pin, pu, pd;
	logic [31:0] rdata_o;
	logic        valid, pen, psec, pusb, v18;
	logic [1:0]  jtag, boot;
	int          miscompares     = 0;
	int          samples_checked = 0;
	int          cyc             = 0;
	bsl_top uut (.mclk_i(mclk_i), .srst_i(srst_i), .strap_pin_i(pin),
		.fuse_debug_strap_select_i(fz[0]), .fuse_usb_debug_off_i(fz[1]),
		.fuse_pin_debug_off_i(fz[2]), .fuse_flash_supply_force_i(fz[3]),
		.fuse_flash_supply_high_i(fz[4]), .fuse_print_port_select_i(fz[5]),
		.fuse_usb_serial_off_i(fz[6]), .fuse_usb_device_off_i(fz[7]),
		.fuse_print_gate_mode_i(fz[9:8]), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .pull_up_en_o(pu), .pull_dn_en_o(pd),
		.strap_valid_o(valid), .jtag_src_o(jtag), .boot_mode_o(boot),
		.flash_supply_1v8_o(v18), .print_usb_o(pusb), .print_enable_o(pen),
		.print_secondary_o(psec));
	bsl_strap_model pm (.mclk_i(mclk_i), .valid_i(valid), .level_i(lvl), .drive_i(drv),
		.pull_up_en_i(pu), .pull_dn_en_i(pd), .pin_o(pin));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] dec(input logic [3:0] s, input logic [9:0] f);
		logic [1:0] j;
		logic       u;
		logic       g;
		case ({f[2], f[1]})
			2'b00: j = f[0] ? (s[3] ? 2'h2 : 2'h1) : 2'h2;
			2'b10: j = 2'h2;
			2'b01: j = 2'h1;
			default: j = 2'h0;
		endcase
		u = !f[6] && !f[7];
		g = f[9:8] == 2'h0 || (f[9:8] == 2'h1 && !s[2]) || (f[9:8] == 2'h2 && s[2]);
		return {f[5], !u && g, u, f[3] ? !f[4] : s[1], s[0] ? 2'h1 : (s[2] ? 2'h2 : 2'h0), j};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		// twenty resets of the minimum width fit well inside this
		if (cyc == 60000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		logic [3:0]  s, m, es;
		logic [9:0]  f;
		logic [31:0] d;
		logic [7:0]  e;
		int          k;
		void'($urandom(32'h1791C9BE));
		repeat (16) @(posedge mclk_i);
		srst_i <= 1'b0;
		for (int t = 0; t < 20; t++) begin
			s = 4'($urandom);
			m = 4'($urandom) | 4'h8;
			f = 10'($urandom);
			f[9:8] = 2'(t);
			f[2:1] = 2'(t >> 2);
			es = (s & m) | (4'h1 & ~m);
			e = dec(es, f);
			@(posedge mclk_i);
			srst_i <= 1'b1;
			lvl <= s;
			drv <= m;
			fz <= f;
			repeat (bsl_pkg::RST_MIN_CYC) @(posedge mclk_i);
			#1 chk({24'h0, pu, pd}, {24'h0, bsl_pkg::PULL_UP_MASK, bsl_pkg::PULL_DN_MASK});
			@(posedge mclk_i);
			srst_i <= 1'b0;
			k = 0;
			while (valid !== 1'b1 && k < 8) begin
				@(posedge mclk_i);
				k++;
			end
			repeat (4) @(posedge mclk_i);
			#1 chk({31'h0, valid}, 32'h1);
			chk({24'h0, pu, pd}, 32'h0);
			bus_rd(bsl_pkg::ADDR_STRAP, d);
			chk(d, {27'h0, 1'b1, es});
			bus_wr(bsl_pkg::ADDR_STRAP, ~d);
			bus_rd(bsl_pkg::ADDR_STRAP, d);
			chk(d, {27'h0, 1'b1, es});
			bus_rd(bsl_pkg::ADDR_SELECT, d);
			chk(d, {24'h0, e});
			chk({24'h0, psec, pen, pusb, v18, boot, jtag}, {24'h0, e});
			bus_rd(4'hC, d);
			chk(d, 32'h0);
			bus_wr(bsl_pkg::ADDR_CTRL, 32'h1);
			chk({31'h0, pen}, 32'h0);
			bus_wr(bsl_pkg::ADDR_CTRL, 32'h0);
			chk({31'h0, pen}, {31'h0, e[6]});
		end
		wrap_up();
	end
endmodule
